// File: shared/csfb_map.vh
// Purpose: register offsets, field positions and reset values of the
//          codec status and flag bank
// Assumes: 8-bit registers on an 8-bit register address
// Notes:   included by hdl/csfb_flag_bank.v
`ifndef CSFB_MAP_VH
`define CSFB_MAP_VH

`define CSFB_OFF_BUS_COND      8'h22
`define CSFB_OFF_RSVD_A        8'h23
`define CSFB_OFF_ADC_FLAGS     8'h24
`define CSFB_OFF_DAC_POWER     8'h25
`define CSFB_OFF_DAC_GAIN      8'h26
`define CSFB_OFF_OVERFLOW      8'h27
`define CSFB_OFF_RSVD_B_FIRST  8'h28
`define CSFB_OFF_RSVD_B_LAST   8'h2b
`define CSFB_OFF_DAC_EVENT     8'h2c
`define CSFB_OFF_ADC_EVENT     8'h2d

`define CSFB_RST_BUS_COND      8'h00
`define CSFB_RST_RSVD          8'h00
`define CSFB_RST_ADC_EVENT     8'h00

`define CSFB_BIT_GCALL_EN      5

`define CSFB_BIT_ADC_GAIN_OK   7
`define CSFB_BIT_ADC_POWER     6
`define CSFB_BIT_GAIN_LOOP_SAT 5

`define CSFB_BIT_DACL_POWER    7
`define CSFB_BIT_LEFT_HEADPHONE  5
`define CSFB_BIT_SPK_POWER     4
`define CSFB_BIT_DACR_POWER    3
`define CSFB_BIT_RIGHT_HEADPHONE 1

`define CSFB_BIT_DACL_GAIN_OK  4
`define CSFB_BIT_DACR_GAIN_OK  0

`define CSFB_BIT_DACL_OVF      7
`define CSFB_BIT_DACR_OVF      6
`define CSFB_BIT_DAC_SHIFT_OVF 5
`define CSFB_BIT_ADC_OVF       3
`define CSFB_BIT_ADC_SHIFT_OVF 1

`define CSFB_BIT_SHORT         7
`define CSFB_BIT_BUTTON        5
`define CSFB_BIT_PLUG          4
`define CSFB_BIT_COMPRESSOR_LEFT  3
`define CSFB_BIT_COMPRESSOR_RIGHT 2

`endif

// File: hdl/csfb_flag_bank.v
// Purpose: status and flag registers of the codec control space, read and
//          written by the serial control bus engine
// Assumes: the bus engine presents one-cycle read and write strobes with an
//          8-bit register address; flag sources are synchronous levels
// Notes:   read data is registered, valid the cycle after the read strobe
`timescale 1ns/1ps
`include "csfb_map.vh"

// Behaviour
// - general call accepted only while enable bit set
// - adc flag D7 shows gain settled
// - adc flag D6 shows converter powered
// - adc flag D5 shows gain loop saturated
// - saturation flag sticky, cleared by its read
// - dac power D7 left, D3 right converter
// - dac power D5 left, D1 right driver
// - dac power D4 shows speaker driver powered
// - dac gain D4 left, D0 right settled
// - overflow D7 left, D6 right dac
// - overflow D5 shows dac shifter overflow
// - overflow D3 shows adc overflow
// - overflow D1 shows adc shifter overflow
// - event D7 shows short circuit detected
// - event D5 shows headset button pressed
// - event D4 shows headset plug change
// - event D3 left, D2 right above threshold
module csfb_flag_bank
(
   input  wire       REF_CLK_IN,
   input  wire       RESET_N_IN,
   input  wire       REG_WR_IN,
   input  wire       REG_RD_IN,
   input  wire [7:0] REG_ADDR_IN,
   input  wire [7:0] REG_WDATA_IN,
   input  wire       GCALL_SEEN_IN,
   input  wire       ADC_GAIN_OK_IN,
   input  wire       ADC_POWER_IN,
   input  wire       AUTOMATIC_GAIN_LOOP_SAT_IN,
   input  wire       DACL_POWER_IN,
   input  wire       DACR_POWER_IN,
   input  wire       LEFT_HEADPHONE_DRIVER_POWER_IN,
   input  wire       RIGHT_HEADPHONE_DRIVER_POWER_IN,
   input  wire       SPK_POWER_IN,
   input  wire       DACL_GAIN_OK_IN,
   input  wire       DACR_GAIN_OK_IN,
   input  wire       DACL_OVF_IN,
   input  wire       DACR_OVF_IN,
   input  wire       DAC_SHIFT_OVF_IN,
   input  wire       ADC_OVF_IN,
   input  wire       ADC_SHIFT_OVF_IN,
   input  wire       SHORT_IN,
   input  wire       BUTTON_IN,
   input  wire       PLUG_CHANGE_IN,
   input  wire       DYNAMIC_RANGE_COMPRESSOR_LEFT_IN,
   input  wire       DYNAMIC_RANGE_COMPRESSOR_RIGHT_IN,
   output reg  [7:0] REG_RDATA_OUT,
   output reg        GCALL_ACCEPT_OUT,
   output reg        GCALL_ENABLE_OUT
);

   reg  [7:0] bus_cond_reg;
   reg  [7:0] rsvd_a_reg;
   reg  [7:0] adc_event_hi_reg;
   reg        adc_gain_ok_reg;
   reg        adc_power_reg;
   reg        dacl_power_reg;
   reg        dacr_power_reg;
   reg        left_headphone_reg;
   reg        right_headphone_reg;
   reg        spk_power_reg;
   reg        dacl_gain_ok_reg;
   reg        dacr_gain_ok_reg;
   reg        dacl_ovf_reg;
   reg        dacr_ovf_reg;
   reg        dac_shift_ovf_reg;
   reg        adc_ovf_reg;
   reg        adc_shift_ovf_reg;
   reg        short_reg;
   reg        button_reg;
   reg        plug_change_reg;
   reg        compressor_left_reg;
   reg        compressor_right_reg;
   reg        gain_loop_sat_reg;
   reg        gain_loop_sat_next;
   reg  [7:0] rdata_next;
   wire [7:0] adc_flags;
   wire [7:0] dac_power;
   wire [7:0] dac_gain;
   wire [7:0] overflow;
   wire [7:0] dac_event;
   wire       rd_adc_flags;

   // one flop per source: the sources are synchronous levels, so a single
   // stage lines them up for the read mux at one cycle of latency
   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         adc_gain_ok_reg <= 1'b0;
      else
         adc_gain_ok_reg <= ADC_GAIN_OK_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         adc_power_reg <= 1'b0;
      else
         adc_power_reg <= ADC_POWER_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         dacl_power_reg <= 1'b0;
      else
         dacl_power_reg <= DACL_POWER_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         dacr_power_reg <= 1'b0;
      else
         dacr_power_reg <= DACR_POWER_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         left_headphone_reg <= 1'b0;
      else
         left_headphone_reg <= LEFT_HEADPHONE_DRIVER_POWER_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         right_headphone_reg <= 1'b0;
      else
         right_headphone_reg <= RIGHT_HEADPHONE_DRIVER_POWER_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         spk_power_reg <= 1'b0;
      else
         spk_power_reg <= SPK_POWER_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         dacl_gain_ok_reg <= 1'b0;
      else
         dacl_gain_ok_reg <= DACL_GAIN_OK_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         dacr_gain_ok_reg <= 1'b0;
      else
         dacr_gain_ok_reg <= DACR_GAIN_OK_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         dacl_ovf_reg <= 1'b0;
      else
         dacl_ovf_reg <= DACL_OVF_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         dacr_ovf_reg <= 1'b0;
      else
         dacr_ovf_reg <= DACR_OVF_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         dac_shift_ovf_reg <= 1'b0;
      else
         dac_shift_ovf_reg <= DAC_SHIFT_OVF_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         adc_ovf_reg <= 1'b0;
      else
         adc_ovf_reg <= ADC_OVF_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         adc_shift_ovf_reg <= 1'b0;
      else
         adc_shift_ovf_reg <= ADC_SHIFT_OVF_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         short_reg <= 1'b0;
      else
         short_reg <= SHORT_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         button_reg <= 1'b0;
      else
         button_reg <= BUTTON_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         plug_change_reg <= 1'b0;
      else
         plug_change_reg <= PLUG_CHANGE_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         compressor_left_reg <= 1'b0;
      else
         compressor_left_reg <= DYNAMIC_RANGE_COMPRESSOR_LEFT_IN;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         compressor_right_reg <= 1'b0;
      else
         compressor_right_reg <= DYNAMIC_RANGE_COMPRESSOR_RIGHT_IN;
   end

   assign adc_flags = {adc_gain_ok_reg, adc_power_reg,
                       gain_loop_sat_reg, 5'h00};

   assign dac_power = {dacl_power_reg, 1'b0,
                       left_headphone_reg, spk_power_reg,
                       dacr_power_reg, 1'b0,
                       right_headphone_reg, 1'b0};

   assign dac_gain  = {3'h0, dacl_gain_ok_reg, 3'h0, dacr_gain_ok_reg};

   assign overflow  = {dacl_ovf_reg, dacr_ovf_reg, dac_shift_ovf_reg, 1'b0,
                       adc_ovf_reg, 1'b0, adc_shift_ovf_reg, 1'b0};

   // reserved bits D6 and D1..D0 read zero
   assign dac_event = {short_reg, 1'b0, button_reg, plug_change_reg,
                       compressor_left_reg,
                       compressor_right_reg, 2'h0};

   assign rd_adc_flags = REG_RD_IN &&
                         (REG_ADDR_IN == `CSFB_OFF_ADC_FLAGS);

   // a saturation seen in the cycle of the clearing read is kept, so an
   // event is never lost between the read and the clear
   always @*
   begin
      gain_loop_sat_next = gain_loop_sat_reg;
      if (rd_adc_flags)
         gain_loop_sat_next = 1'b0;
      if (AUTOMATIC_GAIN_LOOP_SAT_IN)
         gain_loop_sat_next = 1'b1;
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         gain_loop_sat_reg <= 1'b0;
      else
         gain_loop_sat_reg <= gain_loop_sat_next;
   end

   // writable bits: bus condition whole, reserved gap a, adc event top bit
   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         bus_cond_reg     <= `CSFB_RST_BUS_COND;
         rsvd_a_reg       <= `CSFB_RST_RSVD;
         adc_event_hi_reg <= `CSFB_RST_ADC_EVENT;
      end
      else if (REG_WR_IN)
      begin
         // host keeps reserved bits at zero or reset value
         case (REG_ADDR_IN)
            `CSFB_OFF_BUS_COND:  bus_cond_reg     <= REG_WDATA_IN;
            `CSFB_OFF_RSVD_A:    rsvd_a_reg       <= REG_WDATA_IN;
            `CSFB_OFF_ADC_EVENT: adc_event_hi_reg <= {REG_WDATA_IN[7],
                                                      7'h00};
            default:             bus_cond_reg     <= bus_cond_reg;
         endcase
      end
   end
   // dac gain top bits are never written by the host, so they hold no
   // storage here and read zero

   always @*
   begin
      case (REG_ADDR_IN)
         `CSFB_OFF_BUS_COND:  rdata_next = bus_cond_reg;
         `CSFB_OFF_RSVD_A:    rdata_next = rsvd_a_reg;
         `CSFB_OFF_ADC_FLAGS: rdata_next = adc_flags;
         `CSFB_OFF_DAC_POWER: rdata_next = dac_power;
         `CSFB_OFF_DAC_GAIN:  rdata_next = dac_gain;
         `CSFB_OFF_OVERFLOW:  rdata_next = overflow;
         `CSFB_OFF_DAC_EVENT: rdata_next = dac_event;
         `CSFB_OFF_ADC_EVENT: rdata_next = adc_event_hi_reg;
         default:             rdata_next = 8'h00;
      endcase
   end

   always @(posedge REF_CLK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         REG_RDATA_OUT    <= 8'h00;
         GCALL_ACCEPT_OUT <= 1'b0;
         GCALL_ENABLE_OUT <= 1'b0;
      end
      else
      begin
         if (REG_RD_IN)
            REG_RDATA_OUT <= rdata_next;
         GCALL_ENABLE_OUT <= bus_cond_reg[`CSFB_BIT_GCALL_EN];
         GCALL_ACCEPT_OUT <= GCALL_SEEN_IN &&
                             bus_cond_reg[`CSFB_BIT_GCALL_EN];
      end
   end

endmodule // csfb_flag_bank

// File: testbench/csfb_checker.sv
// Purpose: port checks of csfb_flag_bank
// Assumes: read data lands one cycle after the read strobe
// Notes:   flag checks wait for the source to sit still over the read
`timescale 1ns/1ps
module csfb_checker
(
   input wire       REF_CLK_IN,
   input wire       RESET_N_IN,
   input wire       REG_WR_IN,
   input wire       REG_RD_IN,
   input wire [7:0] REG_ADDR_IN,
   input wire [7:0] REG_WDATA_IN,
   input wire [7:0] REG_RDATA_OUT,
   input wire       GCALL_SEEN_IN,
   input wire       GCALL_ACCEPT_OUT,
   input wire       GCALL_ENABLE_OUT,
   input wire       ADC_GAIN_OK_IN,
   input wire       ADC_POWER_IN,
   input wire       AUTOMATIC_GAIN_LOOP_SAT_IN,
   input wire       SPK_POWER_IN,
   input wire       DACL_POWER_IN,
   input wire       DACR_POWER_IN,
   input wire       LEFT_HEADPHONE_DRIVER_POWER_IN,
   input wire       RIGHT_HEADPHONE_DRIVER_POWER_IN,
   input wire       DACL_GAIN_OK_IN,
   input wire       DACR_GAIN_OK_IN,
   input wire       DACL_OVF_IN,
   input wire       DACR_OVF_IN,
   input wire       DAC_SHIFT_OVF_IN,
   input wire       ADC_OVF_IN,
   input wire       ADC_SHIFT_OVF_IN,
   input wire       SHORT_IN,
   input wire       BUTTON_IN,
   input wire       PLUG_CHANGE_IN,
   input wire       DYNAMIC_RANGE_COMPRESSOR_LEFT_IN,
   input wire       DYNAMIC_RANGE_COMPRESSOR_RIGHT_IN
);
   wire [7:0] ra  = REG_RD_IN ? REG_ADDR_IN : 8'h00;
   wire [1:0] adc = {ADC_GAIN_OK_IN, ADC_POWER_IN};
   wire [7:0] pwr = {DACL_POWER_IN, 1'b0, LEFT_HEADPHONE_DRIVER_POWER_IN,
                     SPK_POWER_IN, DACR_POWER_IN, 1'b0,
                     RIGHT_HEADPHONE_DRIVER_POWER_IN, 1'b0};
   wire [7:0] ovf = {DACL_OVF_IN, DACR_OVF_IN, DAC_SHIFT_OVF_IN, 1'b0,
                     ADC_OVF_IN, 1'b0, ADC_SHIFT_OVF_IN, 1'b0};
   wire [7:0] evt = {SHORT_IN, 1'b0, BUTTON_IN, PLUG_CHANGE_IN,
                     DYNAMIC_RANGE_COMPRESSOR_LEFT_IN,
                     DYNAMIC_RANGE_COMPRESSOR_RIGHT_IN, 2'h0};
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RESET_N_IN);
   gcall_accept_a: assert property (GCALL_ACCEPT_OUT ==
      ($past(GCALL_SEEN_IN) && $past(GCALL_ENABLE_OUT))) else $error("accept");
   gcall_enable_a: assert property (REG_WR_IN && REG_ADDR_IN == 8'h22
      |-> ##2 GCALL_ENABLE_OUT == $past(REG_WDATA_IN[5], 2))
      else $error("enable");
   adc_flags_a: assert property (ra == 8'h24 && $stable(adc)
      && $past(RESET_N_IN) |=> REG_RDATA_OUT[7:6] == $past(adc))
      else $error("adc flags");
   sat_clear_a: assert property ((ra == 8'h24
      && !AUTOMATIC_GAIN_LOOP_SAT_IN) [*3] |=> !REG_RDATA_OUT[5])
      else $error("saturation not cleared");
   dac_power_a: assert property (ra == 8'h25 && $stable(pwr)
      && $past(RESET_N_IN) |=> REG_RDATA_OUT == $past(pwr)) else $error("pwr");
   overflow_a: assert property (ra == 8'h27 && $stable(ovf)
      && $past(RESET_N_IN) |=> REG_RDATA_OUT == $past(ovf)) else $error("ovf");
   dac_event_a: assert property (ra == 8'h2c && $stable(evt)
      && $past(RESET_N_IN) |=> REG_RDATA_OUT == $past(evt)) else $error("evt");
   read_hold_a: assert property (!REG_RD_IN
      |=> $stable(REG_RDATA_OUT)) else $error("read data moved");
endmodule // csfb_checker
bind csfb_flag_bank csfb_checker i_csfb_checker (.*);

// File: testbench/csfb_host_model.sv
// Purpose: serial-bus host side of the flag bank register port
// Assumes: strobes change by nonblocking assignment at the rising edge
// Notes:   writes carry only the general-call enable bit
`timescale 1ns/1ps
module csfb_host_model
(
   input  wire       clk_in,
   input  wire [7:0] rdata_in,
   output reg        wr_out = 1'b0,
   output reg        rd_out = 1'b0,
   output reg  [7:0] addr_out = 8'h00,
   output reg  [7:0] wdata_out = 8'h00
);
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk_in);
      wr_out <= (a != 8'h26);
      addr_out <= a;
      wdata_out <= d & 8'h20;
      @(posedge clk_in);
      wr_out <= 1'b0;
   endtask
   // n reads back to back, the last one is returned
   task rd(input [7:0] a, input integer n, output [7:0] d);
      @(posedge clk_in);
      rd_out <= 1'b1;
      addr_out <= a;
      repeat (n) @(posedge clk_in);
      rd_out <= 1'b0;
      #1 d = rdata_in;
   endtask
endmodule // csfb_host_model

// File: testbench/test_csfb_flag_bank.sv
// Purpose: self-checking bench of csfb_flag_bank
// Assumes: 40 MHz clock, flags read two cycles after they change
// Notes:   sources walk one at a time, then nearly all together, so a swapped bit shows
`timescale 1ns/1ps
module test_csfb_flag_bank;
   localparam [63:0] ADDRS = 64'h2425_2627_2c28_2b30;
   reg         clk = 1'b0, rst_n = 1'b0, seen = 1'b0, sat = 1'b0;
   reg  [19:0] s = 20'h0;
   reg  [7:0]  d;
   wire        wr, rd, acc, ena;
   wire [7:0]  addr, wdata, rdata;
   integer     fails = 0, checks = 0, cyc = 0;
   initial forever #12.5 clk = ~clk;
   csfb_host_model i_csfb_host_model (.clk_in(clk), .rdata_in(rdata),
      .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
   csfb_flag_bank i_csfb_flag_bank (.REF_CLK_IN(clk), .RESET_N_IN(rst_n),
      .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata), .GCALL_SEEN_IN(seen), .ADC_GAIN_OK_IN(s[0]),
      .ADC_POWER_IN(s[1]), .AUTOMATIC_GAIN_LOOP_SAT_IN(sat),
      .DACL_POWER_IN(s[3]), .DACR_POWER_IN(s[4]),
      .LEFT_HEADPHONE_DRIVER_POWER_IN(s[5]),
      .RIGHT_HEADPHONE_DRIVER_POWER_IN(s[6]),
      .SPK_POWER_IN(s[7]), .DACL_GAIN_OK_IN(s[8]), .DACR_GAIN_OK_IN(s[9]),
      .DACL_OVF_IN(s[10]), .DACR_OVF_IN(s[11]), .DAC_SHIFT_OVF_IN(s[12]),
      .ADC_OVF_IN(s[13]), .ADC_SHIFT_OVF_IN(s[14]), .SHORT_IN(s[15]),
      .BUTTON_IN(s[16]), .PLUG_CHANGE_IN(s[17]),
      .DYNAMIC_RANGE_COMPRESSOR_LEFT_IN(s[18]),
      .DYNAMIC_RANGE_COMPRESSOR_RIGHT_IN(s[19]), .REG_RDATA_OUT(rdata),
      .GCALL_ACCEPT_OUT(acc), .GCALL_ENABLE_OUT(ena));
   function [7:0] exp_of(input [7:0] a, input [19:0] v);
      case (a)
         8'h24: exp_of = {v[0], v[1], 6'h00};
         8'h25: exp_of = {v[3], 1'b0, v[5], v[7],
                          v[4], 1'b0, v[6], 1'b0};
         8'h26: exp_of = {3'h0, v[8], 3'h0, v[9]};
         8'h27: exp_of = {v[10], v[11], v[12], 1'b0,
                          v[13], 1'b0, v[14], 1'b0};
         8'h2c: exp_of = {v[15], 1'b0, v[16], v[17],
                          v[18], v[19], 2'h0};
         default: exp_of = 8'h00;
      endcase
   endfunction
   task chk(input string n, input [7:0] seen_v, input [7:0] exp_v);
      checks = checks + 1;
      if (seen_v !== exp_v)
      begin
         fails = fails + 1;
         $display("Error %s expected %h seen %h", n, exp_v, seen_v);
      end
   endtask
   task t_gcall;
      integer k;
      for (k = 0; k < 2; k++)
      begin
         i_csfb_host_model.wr(8'h22, {2'h0, ~k[0], 5'h00});
         @(posedge clk) seen <= 1'b1;
         @(posedge clk) seen <= 1'b0;
         #1 chk("accept", {7'h0, acc}, {7'h0, ~k[0]});
         chk("enable", {7'h0, ena}, {7'h0, ~k[0]});
         i_csfb_host_model.rd(8'h22, 1, d);
         chk("bus cond", d, {2'h0, ~k[0], 5'h00});
      end
   endtask
   task t_walk;
      integer i, j;
      for (i = 0; i <= 20; i++)
      begin
         @(posedge clk) s <= (i == 20) ? 20'hffffb : 20'h1 << i;
         repeat (2) @(posedge clk);
         for (j = 0; j < 8; j++)
         begin
            i_csfb_host_model.rd(ADDRS[8*j +: 8], 1, d);
            chk("flags", d, exp_of(ADDRS[8*j +: 8], s));
         end
      end
   endtask
   // run twice: the sticky bit must set again when saturation recurs
   task t_sat;
      @(posedge clk) s <= 20'h0;
      sat <= 1'b1;
      repeat (2) @(posedge clk);
      sat <= 1'b0;
      repeat (2) @(posedge clk);
      i_csfb_host_model.rd(8'h25, 1, d);
      chk("other read", d, 8'h00);
      i_csfb_host_model.rd(8'h24, 1, d);
      chk("sat set", d, 8'h20);
      i_csfb_host_model.rd(8'h24, 3, d);
      chk("sat clear", d, 8'h00);
   endtask
   task wrap_up;
      if (fails == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 3000)
      begin
         fails = fails + 1;
         wrap_up;
      end
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_gcall;
      t_walk;
      t_sat;
      t_sat;
      wrap_up;
   end
endmodule // test_csfb_flag_bank
